//--- hdl/cdpc_top.sv
// charger detect / power control register and its analog control outputs
// assumes the link delivers one-cycle register strobes on ref_clk and that
// detector, comparator and mode levels come from outside this clock domain
// Functional notes
// - read 3Dh, write 3Dh, set 3Eh, clear 3Fh
// - no override: bit 7 reports charger detect
// - override: bit 7 drives indicator pin level
// - bit 7 survives soft reset
// - bit 6 enables source, sink, reference
// - bit 5 shows DM above reference
// - bit 4 pull-up only sync and session valid
// - UART mode forces DP weak pull-up on
// - override selects indicator pin source
// - done bit reads one after auto detection
module cdpc_top (
    // clock, enable, resets
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic soft_rst,
    // register access from the link
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // analog status levels
    input wire logic auto_charger_found,
    input wire logic auto_detect_done,
    input wire logic dm_comparator,
    input wire logic vbus_session_valid,
    input wire logic sync_mode,
    input wire logic uart_mode,
    // analog controls
    output logic charger_indicator_pin,
    output logic sense_voltage_source,
    output logic sense_current_sink,
    output logic sense_reference,
    output logic dp_weak_pullup_enable,
    output logic bvalid_fall_enable,
    output logic bvalid_rise_enable
);
    // synchronised copies of the detector, comparator and mode levels
    logic [5:0] levels_s;
    logic found_s;
    logic done_s;
    logic dm_s;
    logic sess_s;
    logic sync_s;
    logic uart_s;

    // control byte, bit 7 drive value and the image the link reads
    logic charger_result_or_drive_q;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] view;

    // access decode
    logic hit_write;
    logic hit_set;
    logic hit_clear;
    logic wr_hit;
    logic rd_hit;
    logic drive_wr_en;
    logic pullup_d;

    // the status bits must never be storable, or writes would leak into them
    initial begin
        if (cdpc_pkg::WRITE_MASK[cdpc_pkg::BIT_DM_LEVEL]) begin
            $error("cdpc_top: comparator bit must not be writable");
        end
        if (cdpc_pkg::WRITE_MASK[cdpc_pkg::BIT_DONE]) begin
            $error("cdpc_top: detection done bit must not be writable");
        end
    end

    cdpc_sync #(.WIDTH(6)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in({auto_charger_found, auto_detect_done, dm_comparator,
                   vbus_session_valid, sync_mode, uart_mode}),
        .sync_out(levels_s)
    );

    assign found_s = levels_s[5];
    assign done_s = levels_s[4];
    assign dm_s = levels_s[3];
    assign sess_s = levels_s[2];
    assign sync_s = levels_s[1];
    assign uart_s = levels_s[0];

    // register image as the link sees it
    always_comb begin
        view = ctrl_q;
        view[cdpc_pkg::BIT_RESULT] = ctrl_q[cdpc_pkg::BIT_OVERRIDE]
            ? charger_result_or_drive_q : found_s;
        view[cdpc_pkg::BIT_DM_LEVEL] = dm_s;
        view[cdpc_pkg::BIT_DONE] = done_s;
    end

    // one decode per access kind; other addresses do nothing
    assign hit_write = reg_wr && reg_addr == cdpc_pkg::ADDR_WRITE;
    assign hit_set = reg_wr && reg_addr == cdpc_pkg::ADDR_SET;
    assign hit_clear = reg_wr && reg_addr == cdpc_pkg::ADDR_CLEAR;
    assign wr_hit = hit_write || hit_set || hit_clear;
    assign rd_hit = reg_rd && reg_addr == cdpc_pkg::ADDR_WRITE;

    // bit 7 follows a write only once override was already on before the
    // access, so setting override and bit 7 together leaves bit 7 alone
    assign drive_wr_en = wr_hit && ctrl_q[cdpc_pkg::BIT_OVERRIDE];

    // per-bit next value: set and clear work on the image the link reads
    for (genvar i = 0; i < 8; i++) begin : g_bit
        always_comb begin
            if (!cdpc_pkg::WRITE_MASK[i]) begin
                ctrl_d[i] = 1'b0;
            end else if (hit_write) begin
                ctrl_d[i] = reg_wdata[i];
            end else if (hit_set) begin
                ctrl_d[i] = view[i] | reg_wdata[i];
            end else if (hit_clear) begin
                ctrl_d[i] = view[i] & ~reg_wdata[i];
            end else begin
                ctrl_d[i] = ctrl_q[i];
            end
        end
    end

    // control bits other than bit 7; soft reset also restores them
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= cdpc_pkg::RESET_VALUE;
        end else if (clk_en) begin
            if (soft_rst) begin
                ctrl_q <= cdpc_pkg::RESET_VALUE;
            end else if (wr_hit) begin
                ctrl_q <= {1'b0, ctrl_d[6:0]};
            end
        end
    end

    // bit 7 drive value: soft reset leaves it; hard reset clears it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            charger_result_or_drive_q <= 1'b0;
        end else if (clk_en) begin
            if (drive_wr_en) begin
                charger_result_or_drive_q <= ctrl_d[cdpc_pkg::BIT_RESULT];
            end
        end
    end

    // read strobe answered one cycle later
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= rd_hit;
        end
    end

    // read data holds until the next read of the register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (rd_hit) begin
                reg_rdata <= view;
            end
        end
    end

    // charger indicator: detector result, or the drive value under override
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            charger_indicator_pin <= 1'b0;
        end else if (clk_en) begin
            charger_indicator_pin <= view[cdpc_pkg::BIT_RESULT];
        end
    end

    // source, sink and reference always switch together
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sense_voltage_source <= 1'b0;
            sense_current_sink <= 1'b0;
            sense_reference <= 1'b0;
        end else if (clk_en) begin
            sense_voltage_source <= ctrl_q[cdpc_pkg::BIT_SRC_EN];
            sense_current_sink <= ctrl_q[cdpc_pkg::BIT_SRC_EN];
            sense_reference <= ctrl_q[cdpc_pkg::BIT_SRC_EN];
        end
    end

    // uart mode forces the pull-up regardless of the register bit
    assign pullup_d = uart_s
        || (ctrl_q[cdpc_pkg::BIT_PULLUP] && sync_s && sess_s);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dp_weak_pullup_enable <= 1'b0;
        end else if (clk_en) begin
            dp_weak_pullup_enable <= pullup_d;
        end
    end

    // edge report enables for the session comparator
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bvalid_fall_enable <= 1'b0;
            bvalid_rise_enable <= 1'b0;
        end else if (clk_en) begin
            bvalid_fall_enable <= ctrl_q[cdpc_pkg::BIT_FALL];
            bvalid_rise_enable <= ctrl_q[cdpc_pkg::BIT_RISE];
        end
    end
endmodule : cdpc_top

//--- common/cdpc_pkg.sv
// package for the charger detect / power control register block
// assumes register accesses arrive already decoded from the link on ref_clk
package cdpc_pkg;
    // register addresses: read/write, set, clear
    localparam logic [5:0] ADDR_WRITE = 6'h3D;
    localparam logic [5:0] ADDR_SET = 6'h3E;
    localparam logic [5:0] ADDR_CLEAR = 6'h3F;
    // bit positions
    localparam int BIT_RESULT = 7;
    localparam int BIT_SRC_EN = 6;
    localparam int BIT_DM_LEVEL = 5;
    localparam int BIT_PULLUP = 4;
    localparam int BIT_FALL = 3;
    localparam int BIT_RISE = 2;
    localparam int BIT_DONE = 1;
    localparam int BIT_OVERRIDE = 0;
    // writable bits (excludes the status bits 5 and 1)
    localparam logic [7:0] WRITE_MASK = 8'hDD;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // settle time after disabling the sense source, enforced by software
    localparam int SETTLE_US = 200;
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
endpackage : cdpc_pkg

//--- hdl/cdpc_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes one clock domain; the first stage feeds only the second
module cdpc_sync #(
    parameter int WIDTH = 1
) (
    // clock and control
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;

    initial begin
        if (WIDTH < 1) begin
            $error("cdpc_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1_q <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end
endmodule : cdpc_sync

//--- sim/cdpc_afe_model.sv
// analog front end model that drives the DM comparator level
// assumes a charger links DP to DM, so DM follows the DP sense source
module cdpc_afe_model (
    // levels
    input wire logic sense_voltage_source,
    input wire logic charger_attached,
    output logic dm_comparator
);
    timeunit 1ns;
    timeprecision 1ps;
    assign dm_comparator = sense_voltage_source && charger_attached;
endmodule : cdpc_afe_model

//--- sim/cdpc_assertions.sv
// port checker for the charger detect register block
// assumes one clock domain and binding to cdpc_top
module cdpc_assertions (
    // control and requests
    input wire logic ref_clk, rst, clk_en, soft_rst, reg_wr, reg_rd, uart_mode,
    input wire logic vbus_session_valid,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // responses and controls
    input wire logic reg_rvalid, sense_voltage_source, sense_current_sink,
    input wire logic sense_reference, dp_weak_pullup_enable, bvalid_rise_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || !clk_en);
    wire rd3d = reg_rd && reg_addr == 6'h3D;
    property p_rv; rd3d |=> reg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read gave no rvalid");
    property p_norv; !rd3d |=> !reg_rvalid; endproperty
    a_norv: assert property (p_norv) else $error("stray rvalid");
    property p_tri; sense_current_sink == sense_voltage_source
        && sense_reference == sense_voltage_source; endproperty
    a_tri: assert property (p_tri) else $error("sense outputs differ");
    property p_wr; reg_wr && reg_addr == 6'h3D && !soft_rst
        |-> ##2 sense_voltage_source == $past(reg_wdata[6], 2); endproperty
    a_wr: assert property (p_wr) else $error("source not written");
    property p_set; reg_wr && reg_addr == 6'h3E && reg_wdata[6] && !soft_rst
        |-> ##2 sense_voltage_source; endproperty
    a_set: assert property (p_set) else $error("set failed");
    property p_soft; soft_rst && !reg_wr
        |-> ##2 !sense_voltage_source && !bvalid_rise_enable; endproperty
    a_soft: assert property (p_soft) else $error("soft reset missed");
    property p_uart; uart_mode [*5] |-> dp_weak_pullup_enable; endproperty
    a_uart: assert property (p_uart) else $error("uart pull-up off");
    property p_pu; (!uart_mode && !vbus_session_valid) [*5] |-> !dp_weak_pullup_enable;
    endproperty
    a_pu: assert property (p_pu) else $error("pull-up without session");
    c_rv: cover property (reg_rvalid);
    c_soft: cover property (soft_rst);
    c_pu: cover property (dp_weak_pullup_enable && !uart_mode);
endmodule : cdpc_assertions
bind cdpc_top cdpc_assertions cdpc_assertions_i (.*);

//--- sim/testbench.sv
// self-checking bench for the charger detect register block
// assumes cdpc_top with the analog front end model beside it
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, soft_rst = 1'h0, uart_mode = 1'h0;
    logic reg_wr = 1'h0, reg_rd = 1'h0, auto_charger_found = 1'h0, auto_detect_done = 1'h0;
    logic sync_mode = 1'h0, charger_attached = 1'h0, vbus_session_valid = 1'h0;
    logic dm_comparator, reg_rvalid, charger_indicator_pin, sense_voltage_source;
    logic sense_current_sink, sense_reference, dp_weak_pullup_enable;
    logic bvalid_fall_enable, bvalid_rise_enable;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    int n_mismatch = 0, total_checks = 0;
    cdpc_top cdpc_top_i (.*);
    cdpc_afe_model cdpc_afe_model_i (.*);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        repeat (4) @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        `CHK("rvalid", a == 6'h3D, reg_rvalid)
        if (a == 6'h3D) `CHK("rdata", e, reg_rdata)
        // hand back at a rising edge so callers drive on the edge
        @(posedge ref_clk);
    endtask : rd
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'h0;
        rd(6'h3D, 8'h00);
        auto_charger_found <= 1'h1;
        auto_detect_done <= 1'h1;
        wr(6'h3C, 8'hFF);
        rd(6'h3D, 8'h82);
        `CHK("pin", 1'h1, charger_indicator_pin)
        wr(6'h3D, 8'hFF);
        rd(6'h3D, 8'h5F);
        `CHK("pin", 1'h0, charger_indicator_pin)
        `CHK("pullup", 1'h0, dp_weak_pullup_enable)
        `CHK("sink", 1'h1, sense_current_sink)
        `CHK("reference", 1'h1, sense_reference)
        `CHK("fall", 1'h1, bvalid_fall_enable)
        `CHK("rise", 1'h1, bvalid_rise_enable)
        wr(6'h3D, 8'hDD);
        rd(6'h3C, 8'h00);
        rd(6'h3D, 8'hDF);
        `CHK("pin", 1'h1, charger_indicator_pin)
        $display("override test done");
        soft_rst <= 1'h1;
        auto_charger_found <= 1'h0;
        @(posedge ref_clk);
        soft_rst <= 1'h0;
        wr(6'h3E, 8'h01);
        rd(6'h3D, 8'h83);
        `CHK("fall", 1'h0, bvalid_fall_enable)
        `CHK("source", 1'h0, sense_voltage_source)
        wr(6'h3F, 8'h81);
        rd(6'h3D, 8'h02);
        `CHK("pin", 1'h0, charger_indicator_pin)
        charger_attached <= 1'h1;
        wr(6'h3E, 8'h40);
        rd(6'h3D, 8'h62);
        wr(6'h3F, 8'h40);
        rd(6'h3D, 8'h02);
        `CHK("sink", 1'h0, sense_current_sink)
        $display("soft reset and sense test done");
        repeat (cdpc_pkg::SETTLE_CYCLES) @(posedge ref_clk);
        vbus_session_valid <= 1'h1;
        sync_mode <= 1'h1;
        wr(6'h3E, 8'h10);
        `CHK("pullup", 1'h1, dp_weak_pullup_enable)
        vbus_session_valid <= 1'h0;
        uart_mode <= 1'h1;
        wr(6'h3D, 8'h22);
        rd(6'h3D, 8'h02);
        `CHK("pullup", 1'h1, dp_weak_pullup_enable)
        $display("pull-up test done");
        tally_and_finish();
    end
endmodule : testbench
